// >>> rtl/dsg_consts.svh
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

// ==========================================
// Register byte offsets (low 12 address bits)
`define DSG_OFS_SWRST 12'h040
`define DSG_OFS_GATECFG 12'h060
`define DSG_OFS_STATUS 12'h070
`define DSG_OFS_MASK 12'h074
`define DSG_OFS_RUNGATE 12'h100
`define DSG_OFS_SLPGATE 12'h118
`define DSG_OFS_DSLGATE 12'h128

// ==========================================
// Field positions
`define DSG_BIT_PWM_RST 20
`define DSG_BIT_KEEPER_RST 6
`define DSG_BIT_WDOG_RST 3
`define DSG_BIT_AUTO_GATE 0
`define DSG_BIT_EV_GATED 0
`define DSG_BIT_EV_MASKED 1
`define DSG_NPORT 8
`define DSG_NEV 2

// ==========================================
// Reset values and implemented-bit masks
`define DSG_SWRST_IMPL 32'h0010_0048
`define DSG_SWRST_RST 32'h0000_0000
`define DSG_GATE_RST 8'h00
`define DSG_HTRANS_NONSEQ 2'h2
`define DSG_HTRANS_SEQ 2'h3

`endif

// >>> rtl/dsg_pkg.sv
package dsg_pkg;
	// Power mode that picks the active gating set
	typedef enum logic [1:0] {
		DSG_MODE_RUN = 2'b00,
		DSG_MODE_SLEEP = 2'b01,
		DSG_MODE_DEEP = 2'b10
	} dsg_mode_t;
	typedef logic [7:0] dsg_gate_t;
	typedef logic [31:0] dsg_word_t;
endpackage

// >>> rtl/dsg_top.sv
// Operation
// [RULE1] Each gating bit drives exactly one port clock enable; set means clocked.
// [RULE2] Accesses to a port whose clock is gated off get a bus fault.
// [RULE3] All gating enables clear at reset; software enables needed ports.
// [RULE4] Deep-sleep enables for ports A..H sit at bits 0..7, read-write.
// [RULE5] Run, sleep, deep-sleep gating sets; latter two need auto gate select.
// [RULE6] In deep sleep, port enables come from the register at 0x128.
// [RULE7] Bits 31:8 of the deep-sleep gating register read as zero.
// [RULE8] Software reset writes are masked by the capability bits.
// [RULE9] Bit 20 of the software reset register resets the PWM module.
// [RULE10] Bit 6 of the software reset register resets the keeper module.
// [RULE11] Bit 3 resets the watchdog; other bits read zero.
// [RULE12] Software reset register at 0x040, cleared to zero at reset.
// [RULE13] A module stays in reset while its bit is set.
//
// The AHB-Lite register port was chosen for this implementation.
`include "dsg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dsg_top (
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire dsg_pkg::dsg_word_t hwdata,
	output dsg_pkg::dsg_word_t hrdata,
	output logic hreadyout,
	output logic hresp,
	// Power mode requests from the core
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	// Capability bits that gate reset writes
	input wire dsg_pkg::dsg_word_t capability_mask_one,
	// Port unit access and fault
	input wire dsg_pkg::dsg_gate_t port_access,
	output dsg_pkg::dsg_gate_t port_fault,
	// Port clock enables, A in bit 0
	output dsg_pkg::dsg_gate_t port_clock_gate,
	// Module resets
	output logic pwm_reset,
	output logic low_power_keeper_reset,
	output logic watchdog_reset,
	// Interrupt
	output logic irq
);
	import dsg_pkg::*;

	// ==========================================
	// Bus address phase capture
	logic wr_pend_q, wr_pend_d;
	logic [11:0] wr_addr_q, wr_addr_d;
	logic rd_now;
	logic [11:0] rd_addr;

	// Valid transfer seen in this cycle
	always_comb begin
		rd_now = 1'b0;
		rd_addr = haddr[11:0];
		wr_pend_d = 1'b0;
		wr_addr_d = wr_addr_q;
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				wr_pend_d = 1'b1;
				wr_addr_d = haddr[11:0];
			end else begin
				rd_now = 1'b1;
			end
		end
	end

	// Address phase registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
		end else if (clk_en) begin
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
		end
	end

	// ==========================================
	// Software-visible registers
	dsg_word_t swrst_q, swrst_d;
	dsg_gate_t run_gate_q, run_gate_d;
	dsg_gate_t slp_gate_q, slp_gate_d;
	dsg_gate_t dsl_gate_q, dsl_gate_d;
	logic auto_gate_q, auto_gate_d;
	logic [1:0] mask_q, mask_d;
	logic blocked_set;
	dsg_word_t swrst_wmask;

	// Data phase write into the addressed register
	always_comb begin
		swrst_d = swrst_q;
		run_gate_d = run_gate_q;
		slp_gate_d = slp_gate_q;
		dsl_gate_d = dsl_gate_q;
		auto_gate_d = auto_gate_q;
		mask_d = mask_q;
		blocked_set = 1'b0;
		swrst_wmask = `DSG_SWRST_IMPL & capability_mask_one; // RULE8
		if (wr_pend_q) begin
			unique case (wr_addr_q)
				`DSG_OFS_SWRST: begin
					swrst_d = hwdata & swrst_wmask; // RULE8 RULE11 RULE13
					blocked_set = |(hwdata & `DSG_SWRST_IMPL & ~swrst_wmask);
				end
				`DSG_OFS_RUNGATE: begin
					run_gate_d = hwdata[7:0];
				end
				`DSG_OFS_SLPGATE: begin
					slp_gate_d = hwdata[7:0];
				end
				`DSG_OFS_DSLGATE: begin
					dsl_gate_d = hwdata[7:0]; // RULE4
				end
				`DSG_OFS_GATECFG: begin
					auto_gate_d = hwdata[`DSG_BIT_AUTO_GATE];
				end
				`DSG_OFS_MASK: begin
					mask_d = hwdata[1:0];
				end
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end
	end

	// Register storage, all cleared at reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			swrst_q <= `DSG_SWRST_RST; // RULE12
			run_gate_q <= `DSG_GATE_RST; // RULE3
			slp_gate_q <= `DSG_GATE_RST; // RULE3
			dsl_gate_q <= `DSG_GATE_RST; // RULE3
			auto_gate_q <= 1'b0;
			mask_q <= 2'b00;
		end else if (clk_en) begin
			swrst_q <= swrst_d;
			run_gate_q <= run_gate_d;
			slp_gate_q <= slp_gate_d;
			dsl_gate_q <= dsl_gate_d;
			auto_gate_q <= auto_gate_d;
			mask_q <= mask_d;
		end
	end

	// ==========================================
	// Power mode and port clock enables
	dsg_mode_t mode_q, mode_d;
	dsg_gate_t gate_q, gate_d;

	// Sleep sets only apply with auto gate select
	always_comb begin
		mode_d = DSG_MODE_RUN;
		if (auto_gate_q && deep_sleep_req) begin
			mode_d = DSG_MODE_DEEP; // RULE5
		end else if (auto_gate_q && sleep_req) begin
			mode_d = DSG_MODE_SLEEP; // RULE5
		end
		unique case (mode_q)
			DSG_MODE_RUN: gate_d = run_gate_q;
			DSG_MODE_SLEEP: gate_d = slp_gate_q;
			DSG_MODE_DEEP: gate_d = dsl_gate_q; // RULE6
			default: gate_d = run_gate_q;
		endcase
	end

	// Mode and enable registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= DSG_MODE_RUN;
			gate_q <= `DSG_GATE_RST; // RULE3
		end else if (clk_en) begin
			mode_q <= mode_d;
			gate_q <= gate_d;
		end
	end

	// One enable and one fault line per port
	genvar gi;
	generate
		for (gi = 0; gi < `DSG_NPORT; gi++) begin : g_port
			assign port_clock_gate[gi] = gate_q[gi]; // RULE1
			assign port_fault[gi] = port_access[gi] & ~gate_q[gi]; // RULE2
		end
	endgenerate

	// ==========================================
	// Event status, read-to-clear
	logic [1:0] stat_q, stat_d;
	logic [1:0] ev;

	// Set wins over the read clear
	always_comb begin
		ev = 2'b00;
		ev[`DSG_BIT_EV_GATED] = |port_fault; // RULE2
		ev[`DSG_BIT_EV_MASKED] = blocked_set;
		stat_d = stat_q | ev;
		if (rd_now && rd_addr == `DSG_OFS_STATUS) begin
			stat_d = ev;
		end
	end

	// Status storage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_q <= 2'b00;
		end else if (clk_en) begin
			stat_q <= stat_d;
		end
	end

	// ==========================================
	// Read data, taken from post-write values
	dsg_word_t rdata_q, rdata_d;

	// Read mux; unmapped and reserved bits read zero
	always_comb begin
		rdata_d = rdata_q;
		if (rd_now) begin
			unique case (rd_addr)
				`DSG_OFS_SWRST: rdata_d = swrst_d; // RULE11
				`DSG_OFS_RUNGATE: rdata_d = {24'h00_0000, run_gate_d};
				`DSG_OFS_SLPGATE: rdata_d = {24'h00_0000, slp_gate_d};
				`DSG_OFS_DSLGATE: rdata_d = {24'h00_0000, dsl_gate_d}; // RULE7
				`DSG_OFS_GATECFG: rdata_d = {31'h0000_0000, auto_gate_d};
				`DSG_OFS_STATUS: rdata_d = {30'h0000_0000, stat_q};
				`DSG_OFS_MASK: rdata_d = {30'h0000_0000, mask_d};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			rdata_q <= rdata_d;
		end
	end

	// ==========================================
	// Outputs
	assign hrdata = rdata_q;
	assign hreadyout = clk_en; // Stall while frozen
	assign hresp = 1'b0;
	assign pwm_reset = swrst_q[`DSG_BIT_PWM_RST]; // RULE9 RULE13
	assign low_power_keeper_reset = swrst_q[`DSG_BIT_KEEPER_RST]; // RULE10 RULE13
	assign watchdog_reset = swrst_q[`DSG_BIT_WDOG_RST]; // RULE11 RULE13
	assign irq = |(stat_q & mask_q);

	// Size hint only; all accesses are word
	logic unused_ok;
	assign unused_ok = ^{hsize, haddr[31:12], htrans[0]};

endmodule // dsg_top

`default_nettype wire

// >>> dv/dsg_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module dsg_checker (
	// Clock
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Gating
	input wire dsg_pkg::dsg_gate_t port_access,
	input wire dsg_pkg::dsg_gate_t port_fault,
	input wire dsg_pkg::dsg_gate_t port_clock_gate,
	input wire dsg_pkg::dsg_word_t capability_mask_one,
	// Resets
	input wire logic pwm_reset,
	input wire logic low_power_keeper_reset,
	input wire logic watchdog_reset
);
	import dsg_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Faults, reset values, masking, freezing
	a_fault_gated: assert property (port_fault == (port_access & ~port_clock_gate))
		else $error("fault map");
	a_gate_rst: assert property ($rose(hresetn) |-> port_clock_gate == 8'h00)
		else $error("gate reset");
	a_swrst_rst: assert property ($rose(hresetn) |-> !(pwm_reset | low_power_keeper_reset | watchdog_reset))
		else $error("reset outputs");
	a_pwm_masked: assert property ($rose(pwm_reset) |-> $past(capability_mask_one[20]))
		else $error("pwm mask");
	a_keep_masked: assert property ($rose(low_power_keeper_reset) |-> $past(capability_mask_one[6]))
		else $error("keeper mask");
	a_wdog_masked: assert property ($rose(watchdog_reset) |-> $past(capability_mask_one[3]))
		else $error("watchdog mask");
	a_gate_frozen: assert property (!$past(clk_en) |-> $stable(port_clock_gate))
		else $error("gate frozen");
	a_hold_frozen: assert property (!$past(clk_en) |-> $stable(pwm_reset) && $stable(watchdog_reset))
		else $error("reset frozen");
	c_gate: cover property ($rose(port_clock_gate[7]));
	c_fault: cover property (|port_fault);
	c_pwm: cover property ($rose(pwm_reset));
endmodule // dsg_checker
`default_nettype wire

// >>> dv/deep_sleep_gating_and_soft_reset_bench.sv
`timescale 1ns/1ps
`default_nettype none
module deep_sleep_gating_and_soft_reset_bench;
	import dsg_pkg::*;
	logic hclk, hresetn, clk_en, hsel, hwrite, sleep_req, deep_sleep_req, hreadyout, hresp, irq;
	logic pwm_reset, low_power_keeper_reset, watchdog_reset;
	logic [31:0] haddr;
	logic [1:0] htrans;
	dsg_word_t hwdata, hrdata, capability_mask_one, rd;
	dsg_gate_t port_access, port_fault, port_clock_gate;
	int num_errors = 0;
	int total_checks = 0;
	// Block under test
	dsg_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .capability_mask_one(capability_mask_one),
		.port_access(port_access), .port_fault(port_fault), .port_clock_gate(port_clock_gate), .pwm_reset(pwm_reset),
		.low_power_keeper_reset(low_power_keeper_reset), .watchdog_reset(watchdog_reset), .irq(irq));
	// Clock
	initial begin
		hclk = 0;
		forever #2 hclk = ~hclk;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string name, dsg_word_t exp, dsg_word_t got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", name, exp, got);
		end
	endtask
	// Bounded wait for hready
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			num_errors++;
			summarize();
		end
	endtask
	// One single AHB transfer
	task automatic xfer(logic w, logic [11:0] a, dsg_word_t wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic t_reset();
		xfer(0, 12'h040, 0);
		chk("swrst", 0, rd);
		xfer(0, 12'h128, 0);
		chk("dsgate", 0, rd);
		chk("gate", 0, port_clock_gate);
	endtask
	task automatic t_gate();
		xfer(1, 12'h128, 32'hFFFF_FFA5);
		xfer(0, 12'h128, 0);
		chk("dsgate", 32'h0000_00A5, rd);
		xfer(1, 12'h060, 32'h0000_0001);
		@(posedge hclk);
		deep_sleep_req <= 1'b1;
		tick(2);
		chk("gate", 8'hA5, port_clock_gate);
		@(posedge hclk);
		port_access <= 8'hFF;
		tick(0);
		chk("fault", 8'h5A, port_fault);
		@(posedge hclk);
		port_access <= 8'h00;
		deep_sleep_req <= 1'b0;
		sleep_req <= 1'b1;
		tick(2);
		chk("gate", 0, port_clock_gate);
		xfer(1, 12'h118, 32'h0000_0003);
		tick(1);
		chk("gate", 8'h03, port_clock_gate);
		@(posedge hclk);
		clk_en <= 1'b0;
		sleep_req <= 1'b0;
		repeat (3) @(posedge hclk);
		clk_en <= 1'b1;
		tick(2);
		chk("gate", 0, port_clock_gate);
	endtask
	task automatic t_swrst();
		@(posedge hclk);
		capability_mask_one <= 32'hFFFF_FFFF;
		xfer(1, 12'h040, 32'hFFFF_FFFF);
		xfer(0, 12'h040, 0);
		chk("swrst", 32'h0010_0048, rd);
		chk("held", 3'h7, {pwm_reset, low_power_keeper_reset, watchdog_reset});
		capability_mask_one <= 32'h0000_0008;
		xfer(1, 12'h040, 0);
		xfer(1, 12'h040, 32'hFFFF_FFFF);
		xfer(0, 12'h040, 0);
		chk("swrst", 32'h0000_0008, rd);
		xfer(1, 12'h040, 0);
		tick(0);
		chk("held", 0, {pwm_reset, low_power_keeper_reset, watchdog_reset});
	endtask
	task automatic t_irq();
		chk("irq", 0, irq);
		xfer(0, 12'h300, 0);
		chk("unmapped", 0, rd);
		xfer(1, 12'h074, 32'h0000_0003);
		tick(1);
		chk("irq", 1, irq);
		xfer(0, 12'h070, 0);
		chk("status", 32'h0000_0003, rd);
		tick(1);
		chk("irq", 0, irq);
	endtask
	// Main sequence
	initial begin
		{hresetn, hsel, hwrite, sleep_req, deep_sleep_req, htrans, haddr, hwdata} = '0;
		{capability_mask_one, port_access} = '0;
		clk_en = 1'b1;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_gate();
		t_swrst();
		t_irq();
		summarize();
	end
endmodule // deep_sleep_gating_and_soft_reset_bench
bind dsg_top dsg_checker chk_u (.*);
`default_nettype wire
